// ==== verilog/mex_exec.sv ====
`timescale 1ns/1ps
// Function
// - increment memory, write back, skip on zero
// - increment into working register, skip on zero
// - skip when selected bit is one
// - skip discards prefetch, adds dummy cycle
// - copy byte to working, skip when zero
// - skip when selected bit is zero
// - subtract by complement plus one, all flags
// - swap nibbles of memory byte in place
// - swapped nibbles into working register only
// - table read from current page
// - table read from last page
// - xor memory into working register
// - xor written to memory, zero flag
// - xor immediate into working, zero flag
module mex_exec
    import mex_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // avalon-mm slave
    input  wire logic [BUS_AW-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [3:0]           avs_byteenable,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // program rom port
    output logic                      rom_rd,
    output logic [ROM_AW-1:0]         rom_addr,
    input  wire logic [ROM_W-1:0]     rom_rdata,
    // fetch pipeline
    output logic                      fetch_discard
);

    typedef enum {
        S_IDLE,
        S_EXEC,
        S_ROM,
        S_DUMMY
    } mex_state_t;

    mex_state_t             state;
    mex_insn_t              insn;
    mex_flags_t             flags;
    logic [DATA_W-1:0]      acc;
    logic [TP_W-1:0]        tptr;
    logic [DATA_W-1:0]      thigh;
    logic [PG_W-1:0]        page;
    logic [DM_AW-1:0]       mptr;
    logic                   last_skip;
    logic [CYC_W-1:0]       last_cyc;
    logic                   ack;
    logic [DATA_W-1:0]      dmem [DM_DEPTH];

    logic [31:0]            wmask;
    logic [31:0]            wdat;
    logic                   req;
    logic                   bus_wr;
    logic                   launch;
    logic                   done;
    logic [DATA_W-1:0]      opd;
    logic                   bit_val;
    logic [DATA_W-1:0]      diff;
    mex_flags_t             sub_flags;
    logic [DATA_W-1:0]      xor_res;
    logic [DATA_W-1:0]      inc_res;
    logic [DATA_W-1:0]      swapped;

    // decoded effects of the current instruction
    logic                   next_skip;
    logic                   do_mem;
    logic                   do_acc;
    logic                   do_flags;
    logic                   do_rom;
    logic [DATA_W-1:0]      next_val;
    mex_flags_t             next_flags;

    // byte-lane masked write data
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
        end
        wdat = avs_writedata & wmask;
    end

    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack;
    assign bus_wr          = avs_write && !ack && (state == S_IDLE);
    assign launch          = bus_wr && (avs_address == OFF_INSN);

    // operand fetch and bit select
    assign opd     = dmem[insn.maddr];
    assign bit_val = opd[insn.bit_sel];
    assign swapped = {opd[3:0], opd[7:4]};

    mex_alu u_alu (
        .acc       (acc),
        .opd       ((insn.op == OP_SUB_IMM || insn.op == OP_XOR_IMM) ? insn.imm : opd),
        .diff      (diff),
        .sub_flags (sub_flags),
        .xor_res   (xor_res),
        .inc_res   (inc_res)
    );

    // instruction decode
    always_comb begin
        next_skip  = 1'b0;
        do_mem     = 1'b0;
        do_acc     = 1'b0;
        do_flags   = 1'b0;
        do_rom     = 1'b0;
        next_val   = opd;
        next_flags = flags;
        case (insn.op)
            OP_INC_SKIP: begin
                next_val  = inc_res;
                do_mem    = 1'b1;
                next_skip = (inc_res == 8'h00);
            end
            OP_INC_WORK_SKIP: begin
                next_val  = inc_res;
                do_acc    = 1'b1;
                next_skip = (inc_res == 8'h00);
            end
            OP_BIT_NZ_SKIP: begin
                next_skip = bit_val;
            end
            OP_MEM_ZERO_SKIP: begin
                next_skip = (opd == 8'h00);
            end
            OP_COPY_ZERO_SKIP: begin
                next_val  = opd;
                do_acc    = 1'b1;
                next_skip = (opd == 8'h00);
            end
            OP_BIT_ZERO_SKIP: begin
                next_skip = !bit_val;
            end
            OP_SUB_MEM, OP_SUB_IMM: begin
                next_val   = diff;
                do_acc     = 1'b1;
                do_flags   = 1'b1;
                next_flags = sub_flags;
            end
            OP_MINUS_TO_MEM: begin
                next_val   = diff;
                do_mem     = 1'b1;
                do_flags   = 1'b1;
                next_flags = sub_flags;
            end
            OP_SWAP_MEM: begin
                next_val = swapped;
                do_mem   = 1'b1;
            end
            OP_SWAP_WORK: begin
                next_val = swapped;
                do_acc   = 1'b1;
            end
            OP_TAB_THIS, OP_TAB_FINAL: begin
                do_rom = 1'b1;
            end
            OP_XOR_MEM, OP_XOR_IMM: begin
                next_val     = xor_res;
                do_acc       = 1'b1;
                do_flags     = 1'b1;
                next_flags.z = (xor_res == 8'h00);
            end
            OP_XOR_TO_MEM: begin
                next_val     = xor_res;
                do_mem       = 1'b1;
                do_flags     = 1'b1;
                next_flags.z = (xor_res == 8'h00);
            end
            default: begin
                next_skip = 1'b0;
            end
        endcase
    end

    always_comb begin
        rom_rd   = (state == S_EXEC) && do_rom;
        rom_addr = {(insn.op == OP_TAB_FINAL) ? LAST_PAGE : page, tptr};
    end

    // sequencing of execute, rom and dummy cycles
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (launch) begin
                        state <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    if (do_rom) begin
                        state <= S_ROM;
                    end else if (next_skip) begin
                        state <= S_DUMMY;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_ROM: begin
                    state <= S_IDLE;
                end
                S_DUMMY: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    assign done = ((state == S_EXEC) && !do_rom && !next_skip)
                  || (state == S_ROM) || (state == S_DUMMY);

    assign fetch_discard = (state == S_DUMMY);

    // instruction latch
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            insn <= '0;
        end else if (launch) begin
            insn.op      <= mex_op_t'(wdat[INSN_OP_LSB +: INSN_OP_W]);
            insn.bit_sel <= wdat[INSN_BIT_LSB +: 3];
            insn.maddr   <= wdat[INSN_ADDR_LSB +: DM_AW];
            insn.imm     <= wdat[INSN_IMM_LSB +: DATA_W];
        end
    end

    // working register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= ACC_RST;
        end else if (state == S_EXEC && do_acc) begin
            acc <= next_val;
        end else if (bus_wr && avs_address == OFF_ACC) begin
            acc <= wdat[DATA_W-1:0];
        end
    end

    // status flags
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= FLAGS_RST;
        end else if (state == S_EXEC && do_flags) begin
            flags <= next_flags;
        end else if (bus_wr && avs_address == OFF_FLAGS) begin
            flags <= wdat[3:0];
        end
    end

    // table pointer, page and memory window pointer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tptr <= TPTR_RST;
            page <= PAGE_RST;
            mptr <= MPTR_RST;
        end else if (bus_wr) begin
            if (avs_address == OFF_TPTR) begin
                tptr <= wdat[TP_W-1:0];
            end
            if (avs_address == OFF_PAGE) begin
                page <= wdat[PG_W-1:0];
            end
            if (avs_address == OFF_MPTR) begin
                mptr <= wdat[DM_AW-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            thigh <= THIGH_RST;
        end else if (state == S_ROM) begin
            thigh <= rom_rdata[ROM_W-1:DATA_W];
        end
    end

    // data memory writes from execution and bus window
    always_ff @(posedge ref_clk) begin
        if (state == S_EXEC && do_mem) begin
            dmem[insn.maddr] <= next_val;
        end else if (state == S_ROM) begin
            dmem[insn.maddr] <= rom_rdata[DATA_W-1:0];
        end else if (bus_wr && avs_address == OFF_MDATA) begin
            dmem[mptr] <= wdat[DATA_W-1:0];
        end
    end

    // last skip outcome and cycle count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_skip <= 1'b0;
            last_cyc  <= '0;
        end else if (state == S_EXEC) begin
            last_skip <= next_skip && !do_rom;
            last_cyc  <= (next_skip || do_rom) ? CYC_TWO : CYC_ONE;
        end
    end

    // bus answer: one cycle, or end of execution
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else if (done) begin
            ack <= 1'b1;
        end else if (req && !ack && state == S_IDLE && !launch) begin
            ack <= 1'b1;
        end else begin
            ack <= 1'b0;
        end
    end

    // read data, zero for unmapped offsets
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack) begin
            avs_readdata <= '0;
            case (avs_address)
                OFF_INSN: begin
                    avs_readdata <= {insn.imm, insn.maddr, 5'h00, insn.bit_sel,
                                     3'h0, insn.op};
                end
                OFF_ACC: begin
                    avs_readdata[DATA_W-1:0] <= acc;
                end
                OFF_FLAGS: begin
                    avs_readdata[3:0] <= flags;
                end
                OFF_TPTR: begin
                    avs_readdata[TP_W-1:0] <= tptr;
                end
                OFF_THIGH: begin
                    avs_readdata[DATA_W-1:0] <= thigh;
                end
                OFF_PAGE: begin
                    avs_readdata[PG_W-1:0] <= page;
                end
                OFF_STAT: begin
                    avs_readdata[STAT_SKIP] <= last_skip;
                    avs_readdata[STAT_BUSY] <= (state != S_IDLE);
                    avs_readdata[STAT_CYC_LSB +: CYC_W] <= last_cyc;
                end
                OFF_MPTR: begin
                    avs_readdata[DM_AW-1:0] <= mptr;
                end
                OFF_MDATA: begin
                    avs_readdata[DATA_W-1:0] <= dmem[mptr];
                end
                default: begin
                    avs_readdata <= '0;
                end
            endcase
        end
    end

endmodule // mex_exec

// ==== shared/mex_pkg.sv ====
package mex_pkg;

    // datapath and memory geometry
    localparam int DATA_W   = 8;
    localparam int ROM_W    = 16;
    localparam int ROM_AW   = 15;
    localparam int TP_W     = 8;
    localparam int PG_W     = 7;
    localparam int DM_AW    = 8;
    localparam int DM_DEPTH = 256;
    localparam int BUS_AW   = 8;

    // register byte offsets
    localparam logic [BUS_AW-1:0] OFF_INSN  = 8'h00;
    localparam logic [BUS_AW-1:0] OFF_ACC   = 8'h04;
    localparam logic [BUS_AW-1:0] OFF_FLAGS = 8'h08;
    localparam logic [BUS_AW-1:0] OFF_TPTR  = 8'h0C;
    localparam logic [BUS_AW-1:0] OFF_THIGH = 8'h10;
    localparam logic [BUS_AW-1:0] OFF_PAGE  = 8'h14;
    localparam logic [BUS_AW-1:0] OFF_STAT  = 8'h18;
    localparam logic [BUS_AW-1:0] OFF_MPTR  = 8'h1C;
    localparam logic [BUS_AW-1:0] OFF_MDATA = 8'h20;

    // instruction word fields
    localparam int INSN_OP_LSB   = 0;
    localparam int INSN_OP_W     = 5;
    localparam int INSN_BIT_LSB  = 8;
    localparam int INSN_ADDR_LSB = 16;
    localparam int INSN_IMM_LSB  = 24;

    // status fields
    localparam int STAT_SKIP    = 0;
    localparam int STAT_BUSY    = 1;
    localparam int STAT_CYC_LSB = 4;
    localparam int CYC_W        = 2;

    // reset values
    localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
    localparam logic [3:0]        FLAGS_RST = 4'h0;
    localparam logic [TP_W-1:0]   TPTR_RST  = 8'h00;
    localparam logic [DATA_W-1:0] THIGH_RST = 8'h00;
    localparam logic [PG_W-1:0]   PAGE_RST  = 7'h00;
    localparam logic [DM_AW-1:0]  MPTR_RST  = 8'h00;

    // fixed values
    localparam logic [PG_W-1:0]  LAST_PAGE  = 7'h7F;
    localparam logic [CYC_W-1:0] CYC_ONE    = 2'h1;
    localparam logic [CYC_W-1:0] CYC_TWO    = 2'h2;

    // operations
    typedef enum logic [INSN_OP_W-1:0] {
        OP_NOP,
        OP_INC_SKIP,
        OP_INC_WORK_SKIP,
        OP_BIT_NZ_SKIP,
        OP_MEM_ZERO_SKIP,
        OP_COPY_ZERO_SKIP,
        OP_BIT_ZERO_SKIP,
        OP_SUB_MEM,
        OP_MINUS_TO_MEM,
        OP_SUB_IMM,
        OP_SWAP_MEM,
        OP_SWAP_WORK,
        OP_TAB_THIS,
        OP_TAB_FINAL,
        OP_XOR_MEM,
        OP_XOR_TO_MEM,
        OP_XOR_IMM
    } mex_op_t;

    typedef struct packed {
        logic [DATA_W-1:0] imm;
        logic [DM_AW-1:0]  maddr;
        logic [2:0]        bit_sel;
        mex_op_t           op;
    } mex_insn_t;

    typedef struct packed {
        logic signed_range;
        logic z;
        logic half_borrow;
        logic c;
    } mex_flags_t;

endpackage

// ==== verilog/mex_alu.sv ====
`timescale 1ns/1ps
// subtract, exclusive-or and increment datapath with flag results
module mex_alu
    import mex_pkg::*;
(
    // operands
    input  wire logic [DATA_W-1:0] acc,
    input  wire logic [DATA_W-1:0] opd,
    // results
    output logic [DATA_W-1:0]      diff,
    output mex_flags_t             sub_flags,
    output logic [DATA_W-1:0]      xor_res,
    output logic [DATA_W-1:0]      inc_res
);

    logic [DATA_W:0] wide;
    logic [4:0]      low;

    // complement-and-add subtraction
    always_comb begin
        wide = {1'b0, acc} + {1'b0, ~opd} + 9'h001;
        low  = {1'b0, acc[3:0]} + {1'b0, ~opd[3:0]} + 5'h01;
        diff = wide[DATA_W-1:0];
        // carry set means no borrow
        sub_flags.c  = wide[DATA_W];
        sub_flags.half_borrow  = low[4];
        sub_flags.z            = (wide[DATA_W-1:0] == 8'h00);
        sub_flags.signed_range = (acc[7] != opd[7]) && (wide[7] != acc[7]);
    end

    // plain bitwise and increment results
    assign xor_res = acc ^ opd;
    assign inc_res = opd + 8'h01;

endmodule // mex_alu

// ==== sim/mex_rom_model.sv ====
`timescale 1ns/1ps
// program rom behind the table-read port, word is a fixed mix of its address
module mex_rom_model
    import mex_pkg::*;
(
    // clock
    input  wire logic              ref_clk,
    // rom port
    input  wire logic              rom_rd,
    input  wire logic [ROM_AW-1:0] rom_addr,
    output logic [ROM_W-1:0]       rom_rdata
);
    logic [ROM_W-1:0] word  = 16'h0000;
    logic             valid = 1'b0;

    always_ff @(posedge ref_clk) begin
        valid <= rom_rd;
        if (rom_rd) begin
            word <= {rom_addr[7:0] ^ 8'h5A, rom_addr[14:8], 1'b1};
        end
    end

    // outside the answer cycle show the inverse, never a stale copy
    assign rom_rdata = valid ? word : ~word;
endmodule // mex_rom_model

// ==== sim/mex_exec_monitor.sv ====
`timescale 1ns/1ps
// timing checks on the executor's bus, rom and fetch ports
module mex_exec_monitor
    import mex_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rst_b,
    // bus and rom side
    input wire logic [BUS_AW-1:0] avs_address,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic              avs_waitrequest,
    input wire logic              rom_rd,
    input wire logic [ROM_AW-1:0] rom_addr,
    input wire logic              fetch_discard
);
    logic [4:0] op;
    logic       insn;
    logic       skip_op;
    logic       tab_op;

    // decoded view of the pending instruction write
    assign op      = avs_writedata[4:0];
    assign insn    = avs_write && (avs_address == OFF_INSN);
    assign skip_op = (op >= 5'h01) && (op <= 5'h06);
    assign tab_op  = (op == OP_TAB_THIS) || (op == OP_TAB_FINAL);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_discard_single: assert property (fetch_discard |=> !fetch_discard)
        else $error("dummy cycle longer than one clock");
    a_discard_answer: assert property (fetch_discard |=> !avs_waitrequest)
        else $error("no answer after dummy cycle");
    a_discard_cause: assert property (fetch_discard |-> insn && skip_op && avs_waitrequest)
        else $error("dummy cycle without a skip instruction");
    a_plain_timing: assert property ($rose(avs_write) && insn && !skip_op && !tab_op
        |=> avs_waitrequest ##1 !avs_waitrequest) else $error("plain instruction timing");
    a_skip_timing: assert property ($rose(avs_write) && insn && skip_op
        |=> avs_waitrequest ##1 (avs_waitrequest == fetch_discard))
        else $error("skip instruction timing");
    a_table_seq: assert property ($rose(avs_write) && insn && tab_op
        |=> rom_rd ##1 (!rom_rd && avs_waitrequest) ##1 !avs_waitrequest)
        else $error("table read sequence");
    a_rom_cause: assert property (rom_rd |-> insn && tab_op && avs_waitrequest)
        else $error("rom read without table instruction");
    a_final_page: assert property (rom_rd && op == OP_TAB_FINAL
        |-> rom_addr[14:8] == LAST_PAGE) else $error("final page not addressed");

    c_skip: cover property (fetch_discard);
    c_table: cover property (rom_rd && op == OP_TAB_FINAL);
    c_plain: cover property ($rose(avs_write) && insn && op == OP_SUB_MEM);
endmodule // mex_exec_monitor

bind mex_exec mex_exec_monitor i_mex_exec_monitor (.ref_clk, .rst_b, .avs_address,
    .avs_write, .avs_writedata, .avs_waitrequest, .rom_rd, .rom_addr, .fetch_discard);

// ==== sim/mex_exec_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module mex_exec_tb_top
    import mex_pkg::*;
;
    logic              ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic              rom_rd, fetch_discard;
    logic [3:0]        avs_byteenable;
    logic [BUS_AW-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata;
    logic [ROM_AW-1:0] rom_addr;
    logic [ROM_W-1:0]  rom_rdata;
    int                n_errors = 0;
    int                total_checks = 0;

    mex_exec i_mex_exec (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .rom_rd,
        .rom_addr, .rom_rdata, .fetch_discard);
    mex_rom_model i_mex_rom_model (.ref_clk, .rom_rd, .rom_addr, .rom_rdata);

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one bus transfer, n counts the stalled cycles
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output int n);
        n = 0;
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= a;
        avs_writedata <= d;
        // hold the request until waitrequest is sampled low at a rising edge
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            @(posedge ref_clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        int n;
        xfer(1'b0, a, d, q, n);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        int n;
        xfer(1'b1, a, 32'h00000000, q, n);
        `CHK(nm, e, q)
    endtask

    // v holds start memory, acc, immediate, expected memory, expected acc
    task automatic tc(input logic [4:0] op, input logic [2:0] b, input logic [39:0] v,
                      input logic [3:0] ef, input logic sk);
        logic [31:0] q;
        int n;
        wr(OFF_FLAGS, 32'h0000000A);
        wr(OFF_ACC, {24'h000000, v[31:24]});
        wr(OFF_MPTR, 32'h00000030);
        wr(OFF_MDATA, {24'h000000, v[39:32]});
        xfer(1'b0, OFF_INSN, {v[23:16], 8'h30, 5'h00, b, 3'h0, op}, q, n);
        `CHK("cycles", sk ? 3 : 2, n)
        rd_chk("status", OFF_STAT, {26'h0, sk ? CYC_TWO : CYC_ONE, 3'h0, sk});
        rd_chk("acc", OFF_ACC, {24'h000000, v[7:0]});
        rd_chk("flags", OFF_FLAGS, {28'h0000000, ef});
        rd_chk("memory", OFF_MDATA, {24'h000000, v[15:8]});
    endtask

    // table read into memory 40 with pointer 37, current page 12
    task automatic tab(input logic [4:0] op, input logic [6:0] pg);
        logic [31:0] q;
        int n;
        wr(OFF_FLAGS, 32'h0000000A);
        wr(OFF_TPTR, 32'h00000037);
        wr(OFF_PAGE, 32'h00000012);
        wr(OFF_MPTR, 32'h00000040);
        xfer(1'b0, OFF_INSN, {8'h00, 8'h40, 8'h00, 3'h0, op}, q, n);
        `CHK("table cycles", 3, n)
        rd_chk("table low", OFF_MDATA, {24'h000000, pg, 1'b1});
        rd_chk("table high", OFF_THIGH, 32'h0000006D);
        rd_chk("table flags", OFF_FLAGS, 32'h0000000A);
        rd_chk("table status", OFF_STAT, {26'h0, CYC_TWO, 4'h0});
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_byteenable = 4'hF;
        avs_writedata = 32'h00000000;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        for (int i = 1; i < 10; i++) begin
            if (i != 8) rd_chk("reset value", 8'(4 * i), 32'h00000000);
        end
        wr(8'h24, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h24, 32'h00000000);
        wr(OFF_THIGH, 32'h00000055);
        rd_chk("read only", OFF_THIGH, 32'h00000000);
        tc(OP_INC_SKIP, 3'h0, 40'hFF_11_00_00_11, 4'hA, 1'b1);
        tc(OP_INC_SKIP, 3'h0, 40'h7F_11_00_80_11, 4'hA, 1'b0);
        tc(OP_INC_WORK_SKIP, 3'h0, 40'hFF_11_00_FF_00, 4'hA, 1'b1);
        tc(OP_INC_WORK_SKIP, 3'h0, 40'h41_11_00_41_42, 4'hA, 1'b0);
        tc(OP_BIT_NZ_SKIP, 3'h7, 40'h80_11_00_80_11, 4'hA, 1'b1);
        tc(OP_BIT_NZ_SKIP, 3'h0, 40'hFE_11_00_FE_11, 4'hA, 1'b0);
        tc(OP_MEM_ZERO_SKIP, 3'h0, 40'h00_11_00_00_11, 4'hA, 1'b1);
        tc(OP_MEM_ZERO_SKIP, 3'h0, 40'h01_11_00_01_11, 4'hA, 1'b0);
        tc(OP_COPY_ZERO_SKIP, 3'h0, 40'h00_11_00_00_00, 4'hA, 1'b1);
        tc(OP_COPY_ZERO_SKIP, 3'h0, 40'h9C_11_00_9C_9C, 4'hA, 1'b0);
        tc(OP_BIT_ZERO_SKIP, 3'h3, 40'hF7_11_00_F7_11, 4'hA, 1'b1);
        tc(OP_BIT_ZERO_SKIP, 3'h3, 40'h08_11_00_08_11, 4'hA, 1'b0);
        tc(OP_SUB_MEM, 3'h0, 40'h03_05_00_03_02, 4'h3, 1'b0);
        tc(OP_SUB_MEM, 3'h0, 40'h05_03_00_05_FE, 4'h0, 1'b0);
        tc(OP_MINUS_TO_MEM, 3'h0, 40'h01_80_00_7F_80, 4'h9, 1'b0);
        tc(OP_SUB_IMM, 3'h0, 40'h11_44_44_11_00, 4'h7, 1'b0);
        tc(OP_SWAP_MEM, 3'h0, 40'h3C_11_00_C3_11, 4'hA, 1'b0);
        tc(OP_SWAP_WORK, 3'h0, 40'hA5_11_00_A5_5A, 4'hA, 1'b0);
        tc(OP_XOR_MEM, 3'h0, 40'hF0_F0_00_F0_00, 4'hE, 1'b0);
        tc(OP_XOR_TO_MEM, 3'h0, 40'hAA_AA_00_00_AA, 4'hE, 1'b0);
        tc(OP_XOR_TO_MEM, 3'h0, 40'hF0_0F_00_FF_0F, 4'hA, 1'b0);
        tc(OP_XOR_IMM, 3'h0, 40'h11_3C_3C_11_00, 4'hE, 1'b0);
        tc(5'h11, 3'h0, 40'h11_22_33_11_22, 4'hA, 1'b0);
        tc(OP_NOP, 3'h0, 40'h11_22_00_11_22, 4'hA, 1'b0);
        tab(OP_TAB_THIS, 7'h12);
        tab(OP_TAB_FINAL, LAST_PAGE);
        finish_test();
    end
endmodule // mex_exec_tb_top
